// [inc/wd_consts.svh]
// watchdog offsets, field positions, reset values and timing counts
// assumes: included by bare name from package and design files
`ifndef WD_CONSTS_SVH
`define WD_CONSTS_SVH

// register byte offsets
`define WD_OFS_CTL 4'h0
`define WD_OFS_ALT 4'h4
`define WD_OFS_CLR 4'h8

// control register fields
`define WD_B_PEND 30
`define WD_B_SEL_HI 10
`define WD_B_SEL_LO 8
`define WD_B_EN 7
`define WD_B_IRQ 6
`define WD_B_WKF 5
`define WD_B_WAKE_ALLOW 4
`define WD_B_TOF 3
`define WD_B_RESET_OCCURRED_FLAG 2
`define WD_B_RESET_ON_TIMEOUT_ENABLE 1
`define WD_CTL_RST 32'h0000_0700
`define WD_SEL_RST 3'h7

// alternative control fields
`define WD_B_DLY_HI 1
`define WD_B_DLY_LO 0

// counter clear key
`define WD_KEY 32'h0000_5AA5

// forced-enable strap value that leaves the watchdog free
`define WD_FREE_CFG 3'h7

// clock sources
`define WD_SRC_RC 2'h0
`define WD_SRC_XT 2'h1

// rates in Hz and derived divider counts
`define WD_SYS_HZ 100000000
`define WD_RC_HZ 10000
`define WD_XT_HZ 32000
`define WD_RC_DIV (`WD_SYS_HZ / `WD_RC_HZ)
`define WD_XT_DIV (`WD_SYS_HZ / `WD_XT_HZ)
`define WD_FAST_DIV 2048

// delays in watchdog clock periods
`define WD_DLY0 11'h402
`define WD_DLY1 11'h082
`define WD_DLY2 11'h012
`define WD_DLY3 11'h003
`define WD_HOLD 6'h3F
`define WD_LOG_BASE 4
`endif

// [inc/wd_pkg.sv]
// watchdog types: register bus carrier and reset sequencer states
// assumes: wd_consts.svh on the include path
package wd_pkg;
  `include "wd_consts.svh"

  // one register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [31:0] wdata;
  } wd_bus_s;

  // reset sequencer
  typedef enum logic [1:0] {
    WD_IDLE = 2'b00,
    WD_DELAY = 2'b01,
    WD_HOLD = 2'b10
  } wd_state_e;
endpackage

// [core/wd_tick.sv]
// watchdog clock divider: one-cycle tick per watchdog clock period
// assumes: source select is stable logic on the same clock
`timescale 1ns/1ps
`include "wd_consts.svh"
module wd_tick
  import wd_pkg::*;
#(
  parameter int P_RC_DIV = `WD_RC_DIV
) (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic [1:0] i_src,
  output logic o_tick
);
  logic [15:0] div_q;
  logic [15:0] lim;

  ////////////////////////////////////////////////////////////////////////
  // terminal count for the selected source
  always_comb begin
    case (i_src)
      `WD_SRC_RC: lim = 16'(P_RC_DIV - 1);
      `WD_SRC_XT: lim = 16'(`WD_XT_DIV - 1);
      default: lim = 16'(`WD_FAST_DIV - 1);
    endcase
  end

  // free divider, tick on terminal count
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      div_q <= 16'h0000;
      o_tick <= 1'b0;
    end else begin
      o_tick <= (div_q >= lim);
      div_q <= (div_q >= lim) ? 16'h0000 : div_q + 16'h0001;
    end
  end
endmodule // wd_tick

// [core/wd_ensync.sv]
// count enable synchroniser: new enable becomes active after two ticks
// assumes: tick is a one-cycle enable on the same clock
`timescale 1ns/1ps
module wd_ensync (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_tick,
  input wire logic i_req,
  output logic o_act,
  output logic o_pend
);
  logic stg_q;

  // two watchdog clock stages
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stg_q <= 1'b0;
      o_act <= 1'b0;
    end else if (i_tick) begin
      stg_q <= i_req;
      o_act <= stg_q;
    end
  end

  // pending while the request or the first stage differs from the active state
  assign o_pend = (i_req != o_act) || (stg_q != o_act);
endmodule // wd_ensync

// [core/wd_top.sv]
// watchdog: 18-bit up counter, time-out flag, reset delay, reset hold,
// power-down wake-up, three registers on a plain strobe port
// assumes: one 100 MHz clock; watchdog clock is a divided tick;
// strap, source select and power-down inputs are same-clock logic
`timescale 1ns/1ps
`include "wd_consts.svh"

module wd_top
  import wd_pkg::*;
#(
  parameter int P_RC_DIV = `WD_RC_DIV
) (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire wd_bus_s i_bus,
  input wire logic [1:0] i_clk_src,
  input wire logic [2:0] i_forced_on_config,
  input wire logic i_power_down,
  input wire logic i_rst_cause_clr,
  output logic [31:0] o_rd_data,
  output logic o_irq,
  output logic o_wake,
  output logic o_sys_rst,
  output logic o_rst_cause
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // terminal count of the selected interval
  function automatic logic [17:0] wd_lim(input logic [2:0] sel);
    logic [4:0] sh;
    sh = 5'(`WD_LOG_BASE) + {1'b0, sel, 1'b0};
    wd_lim = 18'((19'h00001 << sh) - 19'h00001);
  endfunction

  // last delay count for the selected reset delay
  function automatic logic [10:0] wd_dly(input logic [1:0] sel);
    case (sel)
      2'h0: wd_dly = `WD_DLY0 - 11'h001;
      2'h1: wd_dly = `WD_DLY1 - 11'h001;
      2'h2: wd_dly = `WD_DLY2 - 11'h001;
      default: wd_dly = `WD_DLY3 - 11'h001;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // declarations

  logic forced_q;
  logic strap_done_q;
  logic en_req_q;
  logic [2:0] sel_q;
  logic irq_allow_q;
  logic wake_allow_q;
  logic rst_en_q;
  logic [1:0] dly_sel_q;
  logic tout_flag_q;
  logic wake_flag_q;
  logic rst_flag_q;
  logic [17:0] cnt_q;
  logic [10:0] dly_q;
  logic [5:0] hold_q;
  wd_state_e state_q;
  logic tick;
  logic en_act;
  logic en_pend;
  logic [1:0] src;
  logic wr_ctl;
  logic wr_alt;
  logic key_hit;
  logic tout_ev;
  logic slow_src;
  logic wake_ev;
  logic rst_ev;
  logic hold_end;

  ////////////////////////////////////////////////////////////////////////
  // write decode

  assign wr_ctl = i_bus.wr && (i_bus.addr == `WD_OFS_CTL);
  assign wr_alt = i_bus.wr && (i_bus.addr == `WD_OFS_ALT);
  assign key_hit = i_bus.wr && (i_bus.addr == `WD_OFS_CLR)
                   && (i_bus.wdata == `WD_KEY);

  ////////////////////////////////////////////////////////////////////////
  // forced-enable strap, caught on the clock after reset release

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      forced_q <= 1'b1;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      forced_q <= (i_forced_on_config != `WD_FREE_CFG);
      strap_done_q <= 1'b1;
    end
  end

  // forced mode runs from the 10 kHz oscillator
  assign src = forced_q ? `WD_SRC_RC : i_clk_src;
  assign slow_src = (src == `WD_SRC_RC) || (src == `WD_SRC_XT);

  ////////////////////////////////////////////////////////////////////////
  // watchdog clock tick and enable synchroniser

  wd_tick #(
    .P_RC_DIV(P_RC_DIV)
  ) u_tick (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_src(src),
    .o_tick(tick)
  );

  wd_ensync u_ensync (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_tick(tick),
    .i_req(en_req_q),
    .o_act(en_act),
    .o_pend(en_pend)
  );

  ////////////////////////////////////////////////////////////////////////
  // control fields written by software

  // count enable request; forced on while the strap says so
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      en_req_q <= 1'b0;
    end else if (forced_q && strap_done_q) begin
      en_req_q <= 1'b1;
    end else if (wr_ctl) begin
      en_req_q <= i_bus.wdata[`WD_B_EN];
    end
  end

  // interval, interrupt, wake and reset enables
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sel_q <= `WD_SEL_RST;
      irq_allow_q <= 1'b0;
      wake_allow_q <= 1'b0;
      rst_en_q <= 1'b0;
    end else if (wr_ctl) begin
      sel_q <= i_bus.wdata[`WD_B_SEL_HI:`WD_B_SEL_LO];
      irq_allow_q <= i_bus.wdata[`WD_B_IRQ];
      wake_allow_q <= i_bus.wdata[`WD_B_WAKE_ALLOW];
      rst_en_q <= i_bus.wdata[`WD_B_RESET_ON_TIMEOUT_ENABLE];
    end
  end

  // reset delay select
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      dly_sel_q <= 2'h0;
    end else if (wr_alt) begin
      dly_sel_q <= i_bus.wdata[`WD_B_DLY_HI:`WD_B_DLY_LO];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // up counter

  // time-out when the count reaches the selected interval
  assign tout_ev = tick && en_act && (cnt_q == wd_lim(sel_q));

  // free-running; zeroed by disable, key write or watchdog reset
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_q <= 18'h00000;
    end else if (!en_act) begin
      cnt_q <= 18'h00000;
    end else if (key_hit || rst_ev) begin
      cnt_q <= 18'h00000;
    end else if (tick) begin
      cnt_q <= cnt_q + 18'h00001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // reset sequencer: delay after time-out, then hold system reset

  assign rst_ev = (state_q == WD_DELAY) && tick && !key_hit
                  && (dly_q == wd_dly(dly_sel_q));
  assign hold_end = (state_q == WD_HOLD) && tick
                    && (hold_q == `WD_HOLD - 6'h01);

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= WD_IDLE;
      dly_q <= 11'h000;
      hold_q <= 6'h00;
    end else begin
      case (state_q)
        WD_IDLE: begin
          dly_q <= 11'h000;
          hold_q <= 6'h00;
          if (tout_ev && rst_en_q) begin
            state_q <= WD_DELAY;
          end
        end
        WD_DELAY: begin
          if (key_hit || !rst_en_q) begin
            state_q <= WD_IDLE;
          end else if (rst_ev) begin
            state_q <= WD_HOLD;
          end else if (tick) begin
            dly_q <= dly_q + 11'h001;
          end
        end
        WD_HOLD: begin
          if (hold_end) begin
            state_q <= WD_IDLE;
          end else if (tick) begin
            hold_q <= hold_q + 6'h01;
          end
        end
        default: begin
          state_q <= WD_IDLE;
        end
      endcase
    end
  end

  // system reset request, asserted at once and held for the hold period
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_sys_rst <= 1'b0;
    end else if (rst_ev) begin
      o_sys_rst <= 1'b1;
    end else if (hold_end) begin
      o_sys_rst <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky flags; a setting event wins over a clearing write

  // time-out flag
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tout_flag_q <= 1'b0;
    end else if (tout_ev) begin
      tout_flag_q <= 1'b1;
    end else if (wr_ctl && i_bus.wdata[`WD_B_TOF]) begin
      tout_flag_q <= 1'b0;
    end
  end

  // reset-occurred flag survives the system reset it causes
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_flag_q <= 1'b0;
    end else if (rst_ev) begin
      rst_flag_q <= 1'b1;
    end else if (wr_ctl && i_bus.wdata[`WD_B_RESET_OCCURRED_FLAG]) begin
      rst_flag_q <= 1'b0;
    end
  end

  // wake-up from power-down on a slow source
  assign wake_ev = tout_ev && i_power_down && slow_src
                   && irq_allow_q && wake_allow_q;

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wake_flag_q <= 1'b0;
    end else if (wake_ev) begin
      wake_flag_q <= 1'b1;
    end else if (wr_ctl && i_bus.wdata[`WD_B_WKF]) begin
      wake_flag_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs toward processor, wake and reset status logic

  // interrupt level follows the time-out flag when allowed
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= (tout_flag_q || tout_ev) && irq_allow_q;
    end
  end

  // one-cycle wake pulse
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_wake <= 1'b0;
    end else begin
      o_wake <= wake_ev;
    end
  end

  // reset cause, cleared by the reset status logic
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rst_cause <= 1'b0;
    end else if (rst_ev) begin
      o_rst_cause <= 1'b1;
    end else if (i_rst_cause_clr) begin
      o_rst_cause <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read port: data in the cycle after the read strobe, zero elsewhere

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rd_data <= 32'h0000_0000;
    end else begin
      o_rd_data <= 32'h0000_0000;
      if (i_bus.rd && (i_bus.addr == `WD_OFS_CTL)) begin
        o_rd_data[`WD_B_PEND] <= en_pend;
        o_rd_data[`WD_B_SEL_HI:`WD_B_SEL_LO] <= sel_q;
        o_rd_data[`WD_B_EN] <= en_req_q;
        o_rd_data[`WD_B_IRQ] <= irq_allow_q;
        o_rd_data[`WD_B_WKF] <= wake_flag_q;
        o_rd_data[`WD_B_WAKE_ALLOW] <= wake_allow_q;
        o_rd_data[`WD_B_TOF] <= tout_flag_q;
        o_rd_data[`WD_B_RESET_OCCURRED_FLAG] <= rst_flag_q;
        o_rd_data[`WD_B_RESET_ON_TIMEOUT_ENABLE] <= rst_en_q;
      end else if (i_bus.rd && (i_bus.addr == `WD_OFS_ALT)) begin
        o_rd_data[`WD_B_DLY_HI:`WD_B_DLY_LO] <= dly_sel_q;
      end
    end
  end

endmodule // wd_top

// [verif/wd_chk_properties.sv]
// checker: relations between the watchdog's ports over time
// assumes: bound to wd_top; reset timing runs on the rc source tick
`timescale 1ns/1ps
module wd_chk_properties
  import wd_pkg::*;
#(
  parameter int P_RC_DIV = 4
) (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire wd_bus_s i_bus,
  input wire logic i_power_down,
  input wire logic i_rst_cause_clr,
  input wire logic [31:0] o_rd_data,
  input wire logic o_irq,
  input wire logic o_wake,
  input wire logic o_sys_rst,
  input wire logic o_rst_cause
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  int hi_q;

  ////////////////////////////////////////////////////////////////////////////
  // cycles spent so far in system reset
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      hi_q <= 0;
    end else begin
      hi_q <= o_sys_rst ? hi_q + 1 : 0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read data
  chk_clr_reads0: assert property (
    i_bus.rd && i_bus.addr == 4'h8 |=> o_rd_data == 32'h0)
    else $error("clear register read not zero");
  chk_ctl_resv: assert property (
    i_bus.rd && i_bus.addr == 4'h0 |=> o_rd_data[29:11] == 19'h0
      && !o_rd_data[0])
    else $error("control reserved bits not zero");
  chk_alt_field: assert property (
    i_bus.rd && i_bus.addr == 4'h4 |=> o_rd_data[31:2] == 30'h0)
    else $error("alt control reserved bits not zero");

  ////////////////////////////////////////////////////////////////////////////
  // wake-up and system reset
  chk_wake_pulse: assert property (o_wake |=> !o_wake)
    else $error("wake request longer than one cycle");
  chk_wake_pd: assert property (o_wake |-> $past(i_power_down))
    else $error("wake request outside power-down");
  chk_cause_with: assert property ($rose(o_sys_rst) |-> o_rst_cause)
    else $error("reset without cause indication");
  chk_cause_keep: assert property (
    o_rst_cause && !i_rst_cause_clr |=> o_rst_cause)
    else $error("cause indication dropped without clear");
  chk_hold_len: assert property (
    $fell(o_sys_rst) |-> hi_q == 63 * P_RC_DIV)
    else $error("system reset hold length wrong");

  cover property ($rose(o_sys_rst));
  cover property (o_wake);
  cover property ($rose(o_irq));
endmodule // wd_chk_properties

bind wd_top wd_chk_properties #(.P_RC_DIV(P_RC_DIV)) u_wd_chk_properties (
  .i_sys_clk,
  .i_arst_n,
  .i_bus,
  .i_power_down,
  .i_rst_cause_clr,
  .o_rd_data,
  .o_irq,
  .o_wake,
  .o_sys_rst,
  .o_rst_cause
);

// [verif/wd_sys_model.sv]
// model of the reset controller and power-down logic beside the watchdog
// assumes: same clock; bench asks for power-down and cause clear
`timescale 1ns/1ps
module wd_sys_model (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_pd_req,
  input wire logic i_clr_req,
  input wire logic i_wake,
  output logic o_power_down,
  output logic o_cause_clr
);
  // enter power-down on request, leave it on a wake request
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_power_down <= 1'b0;
      o_cause_clr <= 1'b0;
    end else begin
      o_cause_clr <= i_clr_req;
      if (i_wake) begin
        o_power_down <= 1'b0;
      end else if (i_pd_req) begin
        o_power_down <= 1'b1;
      end
    end
  end
endmodule // wd_sys_model

// [verif/tb_top.sv]
// testbench: registers, intervals, reset path, key clear, wake-up
// assumes: rc divider of 4; strap and source vary only in t_forced
`timescale 1ns/1ps
module tb_top;
  import wd_pkg::*;
  localparam int P = 4;
  logic i_sys_clk = 1'b0;
  logic i_arst_n = 1'b0;
  wd_bus_s i_bus = '0;
  logic pd_req = 1'b0;
  logic clr_req = 1'b0;
  logic [1:0] clk_src = 2'h0;
  logic [2:0] strap = 3'h7;
  logic power_down, cause_clr, irq, wake, sys_rst, rst_cause;
  logic [31:0] rd_data;
  int n_errors = 0;
  int cmp_count = 0;

  // 100 MHz clock
  always #5 i_sys_clk = ~i_sys_clk;

  wd_top #(.P_RC_DIV(P)) u_wd_top (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_bus(i_bus),
    .i_clk_src(clk_src),
    .i_forced_on_config(strap),
    .i_power_down(power_down),
    .i_rst_cause_clr(cause_clr),
    .o_rd_data(rd_data),
    .o_irq(irq),
    .o_wake(wake),
    .o_sys_rst(sys_rst),
    .o_rst_cause(rst_cause)
  );
  wd_sys_model u_wd_sys_model (
    .i_sys_clk(i_sys_clk),
    .i_arst_n(i_arst_n),
    .i_pd_req(pd_req),
    .i_clr_req(clr_req),
    .i_wake(wake),
    .o_power_down(power_down),
    .o_cause_clr(cause_clr)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus cycles, waits and comparison
  task automatic cyc();
    @(posedge i_sys_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_bus <= '{1'b1, 1'b0, a, d};
    @(posedge i_sys_clk);
    i_bus <= '0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge i_sys_clk);
    i_bus <= '{1'b0, 1'b1, a, 32'h0};
    @(posedge i_sys_clk);
    i_bus <= '0;
    #1;
    d = rd_data;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic sig(input int w);
    case (w)
      0: return irq;
      1: return wake;
      2: return sys_rst;
      default: return !sys_rst;
    endcase
  endfunction
  // wait up to mx cycles for a signal, then compare its level with e
  task automatic wait_on(input int w, input int mx, input logic e,
                         output int n);
    n = 0;
    do begin
      cyc();
      n++;
    end while (sig(w) !== 1'b1 && n < mx);
    chk({31'h0, sig(w)}, {31'h0, e});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_regs();
    logic [31:0] d;
    rd(4'h0, d);
    chk(d, 32'h0000_0700);
    rd(4'h8, d);
    chk(d, 32'h0);
    rd(4'hC, d);
    chk(d, 32'h0);
    wr(4'h4, 32'hFFFF_FFFF);
    rd(4'h4, d);
    chk(d, 32'h3);
  endtask
  task automatic t_interval();
    logic [31:0] d;
    int n;
    int t;
    for (int s = 0; s < 5; s++) begin
      t = (2 + 2 ** (4 + 2 * s)) * P;
      wr(4'h0, 32'h0000_00C0 | (s << 8));
      rd(4'h0, d);
      chk(d & 32'h4000_0000, 32'h4000_0000);
      wait_on(0, t + 4 * P, 1'b1, n);
      chk(32'(n >= t - P - 2 && n <= t + P), 32'h1);
      rd(4'h0, d);
      chk(d & 32'h8, 32'h8);
      wr(4'h0, 32'h0000_0008);
      rd(4'h0, d);
      chk(d & 32'h8, 32'h0);
      chk({31'h0, irq}, 32'h0);
      repeat (3 * P) cyc();
      rd(4'h0, d);
      chk(d & 32'h4000_0000, 32'h0);
    end
  endtask
  task automatic t_reset();
    logic [31:0] d;
    int n;
    int dly[4] = '{1026, 130, 18, 3};
    for (int k = 0; k < 4; k++) begin
      wr(4'h4, 32'(k));
      wr(4'h0, 32'h0000_00C2);
      wait_on(0, 30 * P, 1'b1, n);
      wr(4'h8, 32'h0000_5AA4);
      wait_on(2, dly[k] * P + 8, 1'b1, n);
      chk(32'(n), 32'(dly[k] * P - 2));
      wait_on(3, 70 * P, 1'b1, n);
      rd(4'h0, d);
      chk(d & 32'h4, 32'h4);
      chk({31'h0, rst_cause}, 32'h1);
      wr(4'h0, 32'h0000_000C);
      clr_req <= 1'b1;
      @(posedge i_sys_clk);
      clr_req <= 1'b0;
      rd(4'h0, d);
      chk(d & 32'h4, 32'h0);
      repeat (3 * P) cyc();
      chk({31'h0, rst_cause}, 32'h0);
    end
  endtask
  task automatic t_key();
    int n;
    wr(4'h4, 32'h0);
    wr(4'h0, 32'h0000_00C2);
    wait_on(0, 30 * P, 1'b1, n);
    repeat (4 * P) cyc();
    wr(4'h8, 32'h0000_5AA5);
    wait_on(2, 1030 * P, 1'b0, n);
    wr(4'h0, 32'h0000_000C);
  endtask
  task automatic t_wake();
    logic [31:0] d;
    int n;
    @(posedge i_sys_clk);
    pd_req <= 1'b1;
    @(posedge i_sys_clk);
    pd_req <= 1'b0;
    wr(4'h0, 32'h0000_00D0);
    wait_on(1, 30 * P, 1'b1, n);
    rd(4'h0, d);
    chk(d & 32'h20, 32'h20);
    chk({31'h0, power_down}, 32'h0);
    wr(4'h0, 32'h0000_0028);
    rd(4'h0, d);
    chk(d & 32'h28, 32'h0);
  endtask
  // mid-run reset with a new strap and source
  task automatic pulse_rst(input logic [2:0] s, input logic [1:0] c);
    @(posedge i_sys_clk);
    strap <= s;
    clk_src <= c;
    i_arst_n <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    i_arst_n <= 1'b1;
  endtask
  // forced strap holds enable and overrides the fast source with rc
  task automatic t_forced();
    logic [31:0] d;
    int n;
    pulse_rst(3'h0, 2'h2);
    wr(4'h0, 32'h0000_0040);
    rd(4'h0, d);
    chk(d & 32'h80, 32'h80);
    wait_on(0, 30 * P, 1'b1, n);
    wr(4'h0, 32'h0000_0008);
    pulse_rst(3'h7, 2'h0);
    rd(4'h0, d);
    chk(d, 32'h0000_0700);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // verdict and run control
  task automatic end_of_test();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge i_sys_clk);
    i_arst_n <= 1'b1;
    t_regs();
    t_interval();
    t_reset();
    t_key();
    t_wake();
    t_forced();
    end_of_test();
  end
  // run needs about 33k cycles; cut a hang at 50k
  initial begin
    #500_000;
    n_errors++;
    end_of_test();
  end
endmodule // tb_top
